// file: logic/dcrly_top.sv
// Purpose: dual channel relay coil pulse controller
// Assumes: enable already filtered, fault and mode synchronous to clk
// Notes:   commands are synchronised inside the channel qualifiers
`timescale 1ns/100ps
`default_nettype none

module dcrly_top
  import dcrly_pkg::*;
#(
  parameter int unsigned QUAL_CYC = QUAL_CYC_DFLT,  // qualify time, cycles
  parameter int unsigned TMAX_CYC = TMAX_CYC_DFLT   // max on-time, cycles
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // command inputs from the logic source
  input  wire logic commandInA,
  input  wire logic commandInB,
  // dominant controls and protection
  input  wire logic enable,
  input  wire logic thermalFault,
  // output mode, high selects fixed length pulses
  input  wire logic fixedMode,
  // drive requests to the output stages
  output var  logic coilDriveA,
  output var  logic coilDriveB,
  // status
  output var  logic busy,
  output var  logic xorBlocked
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  dcrly_chan_t      chanA;          // channel a status
  dcrly_chan_t      chanB;          // channel b status
  logic             clearA;         // drop channel a progress
  logic             clearB;         // drop channel b progress
  dcrly_state_t     state;          // controller state
  dcrly_state_t     next_state;
  logic [CNT_W-1:0] onCnt;          // cycles the output has been on
  logic [CNT_W-1:0] next_onCnt;
  logic             fixedLatch;     // mode caught at pulse start
  logic             next_fixedLatch;
  logic             next_coilDriveA;
  logic             next_coilDriveB;
  logic             next_busy;
  logic             next_xorBlocked;
  logic             shutDown;       // enable low or thermal fault
  logic             onLimit;        // maximum on-time reached
  logic [CNT_W-1:0] tailCnt;        // follow cycles since input fell
  logic [CNT_W-1:0] next_tailCnt;
  logic             inFell;         // follow input seen low this pulse
  logic             next_inFell;
  logic             tailDone;       // follow tail has run one qualify time

  assign shutDown = !enable || thermalFault;
  assign onLimit  = (onCnt == CNT_W'(TMAX_CYC));
  // output is the input delayed by the qualify time, so it ends that late
  assign tailDone = inFell && (tailCnt == CNT_W'(QUAL_CYC + 1));

  ////////////////////////////////////////////////////////////////////////
  // channel qualifiers, identical for both coils
  dcrly_qual #(
    .QUAL_CYC (QUAL_CYC)
  ) u_qualA (
    .clk    (clk),
    .rst    (rst),
    .cmdIn  (commandInA),
    .clear  (clearA),
    .status (chanA)
  );

  dcrly_qual #(
    .QUAL_CYC (QUAL_CYC)
  ) u_qualB (
    .clk    (clk),
    .rst    (rst),
    .cmdIn  (commandInB),
    .clear  (clearB),
    .status (chanB)
  );

  ////////////////////////////////////////////////////////////////////////
  // controller next state
  always_comb begin
    next_state      = state;
    next_onCnt      = onCnt;
    next_fixedLatch = fixedLatch;
    next_tailCnt    = tailCnt;
    next_inFell     = inFell;
    next_xorBlocked = 1'b0;
    clearA          = 1'b0;
    clearB          = 1'b0;
    if (shutDown) begin
      // dominant: back to the initial inactive state
      next_state   = S_IDLE;
      next_onCnt   = '0;
      next_tailCnt = '0;
      next_inFell  = 1'b0;
      clearA     = 1'b1;
      clearB     = 1'b1;
    end else begin
      unique case (state)
        S_IDLE: begin
          // no follow tail outside a pulse
          next_tailCnt = '0;
          next_inFell  = 1'b0;
          if (chanA.qualified && chanB.qualified) begin
            // both valid: refuse both, wait for new edges
            clearA          = 1'b1;
            clearB          = 1'b1;
            next_xorBlocked = 1'b1;
          end else if (chanA.qualified && !chanB.pending) begin
            // a valid and b not in progress: start a
            next_state      = S_DRIVE_A;
            next_onCnt      = CNT_W'(1);
            next_fixedLatch = fixedMode;
            clearB          = 1'b1;
          end else if (chanB.qualified && !chanA.pending) begin
            // b valid and a not in progress: start b
            next_state      = S_DRIVE_B;
            next_onCnt      = CNT_W'(1);
            next_fixedLatch = fixedMode;
            clearA          = 1'b1;
          end
          // otherwise a result waits on the other pending input
        end
        S_DRIVE_A: begin
          // committed: other input ignored throughout
          clearB = 1'b1;
          if (onLimit || tailDone) begin
            // end at cap, or once the follow tail has run out
            next_state   = S_IDLE;
            next_onCnt   = '0;
            next_tailCnt = '0;
            next_inFell  = 1'b0;
            clearA       = 1'b1;
          end else begin
            next_onCnt = onCnt + CNT_W'(1);
            if (!fixedLatch && (inFell || !chanA.level)) begin
              // input gone: stay on one qualify time more, copying its width
              next_inFell  = 1'b1;
              next_tailCnt = tailCnt + CNT_W'(1);
            end
          end
        end
        S_DRIVE_B: begin
          // mirror of channel a
          clearA = 1'b1;
          if (onLimit || tailDone) begin
            next_state   = S_IDLE;
            next_onCnt   = '0;
            next_tailCnt = '0;
            next_inFell  = 1'b0;
            clearB       = 1'b1;
          end else begin
            next_onCnt = onCnt + CNT_W'(1);
            if (!fixedLatch && (inFell || !chanB.level)) begin
              // input gone: stay on one qualify time more
              next_inFell  = 1'b1;
              next_tailCnt = tailCnt + CNT_W'(1);
            end
          end
        end
        default: begin
          // illegal code: recover safely
          next_state   = S_IDLE;
          next_onCnt   = '0;
          next_tailCnt = '0;
          next_inFell  = 1'b0;
          clearA     = 1'b1;
          clearB     = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output next values, decoded from the next state
  always_comb begin
    next_coilDriveA = (next_state == S_DRIVE_A);
    next_coilDriveB = (next_state == S_DRIVE_B);
    next_busy       = (next_state != S_IDLE);
  end

  // registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= S_IDLE;
      onCnt      <= '0;
      fixedLatch <= 1'b0;
      tailCnt    <= '0;
      inFell     <= 1'b0;
      coilDriveA <= 1'b0;
      coilDriveB <= 1'b0;
      busy       <= 1'b0;
      xorBlocked <= 1'b0;
    end else begin
      state      <= next_state;
      onCnt      <= next_onCnt;
      fixedLatch <= next_fixedLatch;
      tailCnt    <= next_tailCnt;
      inFell     <= next_inFell;
      coilDriveA <= next_coilDriveA;
      coilDriveB <= next_coilDriveB;
      busy       <= next_busy;
      xorBlocked <= next_xorBlocked;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checking helpers: consecutive on cycles per coil
  logic [CNT_W-1:0] runA;
  logic [CNT_W-1:0] runB;

  always_ff @(posedge clk) begin
    if (rst) begin
      runA <= '0;
      runB <= '0;
    end else begin
      runA <= coilDriveA ? runA + CNT_W'(1) : '0;
      runB <= coilDriveB ? runB + CNT_W'(1) : '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // coils never on together
  a_coil_exclusive: assert property (
    !(coilDriveA && coilDriveB))
    else $error("both coils driven");

  // on-time never exceeds the cap
  a_cap_on_time: assert property (
    (coilDriveA |-> runA < CNT_W'(TMAX_CYC)) and (coilDriveB |-> runB < CNT_W'(TMAX_CYC)))
    else $error("pulse longer than maximum on-time");

  // fixed mode pulses last exactly the cap unless cut by shutdown
  a_fixed_length: assert property (
    $fell(coilDriveA) && fixedLatch && $past(enable) && !$past(thermalFault)
      |-> runA == CNT_W'(TMAX_CYC))
    else $error("fixed pulse length wrong");

  // follow mode stays on while the input is still high
  a_follow_end: assert property (
    coilDriveA && !fixedLatch && !inFell && chanA.level && !onLimit && !shutDown |=> coilDriveA)
    else $error("follow pulse ended early");

  // follow pulse ends one qualify time after the input fell
  a_follow_tail: assert property (
    coilDriveA && inFell && tailCnt == CNT_W'(QUAL_CYC + 1) && !shutDown |=> !coilDriveA)
    else $error("follow tail length wrong");

  // enable low or fault clears both drives and state
  a_shutdown_off: assert property (
    shutDown |=> !coilDriveA && !coilDriveB && state == S_IDLE && !busy)
    else $error("drive during shutdown");

  // pulse starts only from a qualified channel
  a_start_qualified: assert property (
    $rose(coilDriveA) |-> $past(chanA.qualified) && !$past(chanB.qualified))
    else $error("pulse without qualification");

  // channel b cannot start while channel a drives
  a_no_overlap: assert property (
    coilDriveA && !shutDown |=> !chanB.qualified && !chanB.pending)
    else $error("other input accepted while driving");

  // stuck high input: no second pulse without a new edge
  a_single_pulse: assert property (
    $fell(coilDriveA) && chanA.level |=> !chanA.qualified [*2])
    else $error("second pulse from held input");

  // both qualified in idle gives a block and no drive
  a_xor_block: assert property (
    state == S_IDLE && chanA.qualified && chanB.qualified && !shutDown
      |=> xorBlocked && !coilDriveA && !coilDriveB)
    else $error("dual qualification not blocked");

  // channel b starts only from its own qualification
  a_start_qualified_b: assert property (
    $rose(coilDriveB) |-> $past(chanB.qualified) && !$past(chanA.qualified))
    else $error("b pulse without qualification");

  // a fault that persists keeps both coils off
  a_fault_holds_off: assert property (
    thermalFault && $past(thermalFault) |-> !coilDriveA && !coilDriveB && !busy)
    else $error("drive while fault persists");

  // busy shows a pulse in progress on either coil
  a_busy_tracks: assert property (
    busy == (coilDriveA || coilDriveB))
    else $error("busy disagrees with drive");

  // configured times stay at or below their range maxima
  a_param_range: assert property (
    QUAL_CYC <= QUAL_CYC_MAX && TMAX_CYC <= TMAX_CYC_MAX)
    else $error("timing parameter out of range");

  // main scenarios
  c_fixed_full: cover property ($fell(coilDriveA) && fixedLatch && runA == CNT_W'(TMAX_CYC));
  c_follow_short: cover property ($fell(coilDriveB) && !fixedLatch && runB < CNT_W'(TMAX_CYC));
  c_xor_seen: cover property (xorBlocked);
  c_enable_abort: cover property (coilDriveA && !enable);
  c_pending_wait: cover property (state == S_IDLE && chanA.qualified && chanB.pending);

endmodule : dcrly_top

`default_nettype wire

// file: logic/dcrly_pkg.sv
// Purpose: shared constants and types of the dual coil relay pulse logic
// Assumes: a single 25 MHz clock, synchronous active high reset
// Notes:   times are kept in microseconds, counts are derived from them
//
// Summary of operation
// - noise on the idle input is ignored
// - no new command until pulse finished
// - other input rising edge discarded while driving
// - both qualified together gives no pulse
// - block covers late second qualification too
// - no pulse runs past the maximum on-time
// - input stuck high gives only one pulse
// - follow mode tracks input, capped at maximum
// - fixed mode drives exactly the maximum on-time
// - input must exceed qualify time first
// - mode changes neither qualification nor cap
// - qualify time settable 128 us to 20 ms
// - maximum on-time settable 1 ms to 350 ms
// - follow pulse starts at qualification, copies width
// - preset variant caps pulse at 150 ms
// - thermal fault stops all drive until cleared
// - commands start only on a rising edge
// - enable low clears outputs and control state
// - preset variant qualifies after 15 ms
package dcrly_pkg;

  // clock rate and cycles per microsecond
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

  // preset variant timing, microseconds
  localparam int unsigned QUAL_TIME_US = 15_000;
  localparam int unsigned TMAX_TIME_US = 150_000;

  // allowed ranges, microseconds
  localparam int unsigned QUAL_MIN_US = 128;
  localparam int unsigned QUAL_MAX_US = 20_000;
  localparam int unsigned TMAX_MIN_US = 1_000;
  localparam int unsigned TMAX_MAX_US = 350_000;

  // derived cycle counts (exact, rate is a whole number of MHz)
  localparam int unsigned QUAL_CYC_DFLT = QUAL_TIME_US * CYC_PER_US;
  localparam int unsigned TMAX_CYC_DFLT = TMAX_TIME_US * CYC_PER_US;
  localparam int unsigned QUAL_CYC_MIN  = QUAL_MIN_US * CYC_PER_US;
  localparam int unsigned QUAL_CYC_MAX  = QUAL_MAX_US * CYC_PER_US;
  localparam int unsigned TMAX_CYC_MIN  = TMAX_MIN_US * CYC_PER_US;
  localparam int unsigned TMAX_CYC_MAX  = TMAX_MAX_US * CYC_PER_US;

  // counter width, holds the largest maximum on-time
  localparam int unsigned CNT_W = 24;

  // control states, one-hot
  typedef enum logic [2:0] {
    S_IDLE    = 3'h1,
    S_DRIVE_A = 3'h2,
    S_DRIVE_B = 3'h4
  } dcrly_state_t;

  // per channel status bundle
  typedef struct packed {
    logic level;      // synchronised input level
    logic pending;    // being qualified
    logic qualified;  // qualified, input still high
  } dcrly_chan_t;

endpackage : dcrly_pkg

// file: logic/dcrly_qual.sv
// Purpose: one command input: synchroniser, edge detect, qualification
// Assumes: clear is asserted by the controller to drop all progress
// Notes:   a fresh rising edge is needed after every clear
`timescale 1ns/100ps
`default_nettype none

module dcrly_qual
  import dcrly_pkg::*;
#(
  parameter int unsigned QUAL_CYC = QUAL_CYC_DFLT
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // command pin and controller clear
  input  wire logic  cmdIn,
  input  wire logic  clear,
  // status towards the controller
  output dcrly_chan_t status
);

  ////////////////////////////////////////////////////////////////////////
  logic             syncMeta;       // first synchroniser stage
  logic             syncLevel;      // second synchroniser stage
  logic             lastLevel;      // delayed level for edge detect
  logic [CNT_W-1:0] qualCnt;        // high cycles since the edge
  logic             pending;        // qualification running
  logic             qualified;      // qualification done
  logic             next_syncMeta;
  logic             next_syncLevel;
  logic             next_lastLevel;
  logic [CNT_W-1:0] next_qualCnt;
  logic             next_pending;
  logic             next_qualified;
  logic             rise;           // low to high seen

  assign rise = syncLevel & ~lastLevel;

  ////////////////////////////////////////////////////////////////////////
  // next values of synchroniser and qualifier
  always_comb begin
    next_syncMeta  = cmdIn;
    next_syncLevel = syncMeta;
    next_lastLevel = syncLevel;
    next_qualCnt   = qualCnt;
    next_pending   = pending;
    next_qualified = qualified;
    if (clear || !syncLevel) begin
      // dropped input or clear: forget everything
      next_qualCnt   = '0;
      next_pending   = 1'b0;
      next_qualified = 1'b0;
    end else if (rise) begin
      // edge starts counting, first high cycle
      next_qualCnt = CNT_W'(1);
      next_pending = 1'b1;
    end else if (pending) begin
      // qualified only when high longer than the qualify time
      if (qualCnt == CNT_W'(QUAL_CYC)) begin
        next_pending   = 1'b0;
        next_qualified = 1'b1;
      end else begin
        next_qualCnt = qualCnt + CNT_W'(1);
      end
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      syncMeta  <= 1'b0;
      syncLevel <= 1'b0;
      lastLevel <= 1'b0;
      qualCnt   <= '0;
      pending   <= 1'b0;
      qualified <= 1'b0;
    end else begin
      syncMeta  <= next_syncMeta;
      syncLevel <= next_syncLevel;
      lastLevel <= next_lastLevel;
      qualCnt   <= next_qualCnt;
      pending   <= next_pending;
      qualified <= next_qualified;
    end
  end

  // status straight from flip-flops
  assign status.level     = syncLevel;
  assign status.pending   = pending;
  assign status.qualified = qualified;

endmodule : dcrly_qual

`default_nettype wire

// file: verification/dcrly_source.sv
// Purpose: logic source model driving the two command pins
// Assumes: pins change only at the falling clock edge
// Notes:   idle pins sit low, as the pin pull-downs would hold them
`timescale 1ns/100ps
`default_nettype none

module dcrly_source (
  // clock
  input  wire logic clk,
  // command pins
  output var  logic cmdA,
  output var  logic cmdB
);
  // idle level low from time zero
  initial begin
    cmdA = 1'b0;
    cmdB = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one high pulse of hi cycles, then one low cycle as a gap
  task automatic pulse(input int ch, input int hi);
    if (ch == 0)
      cmdA = 1'b1;
    else
      cmdB = 1'b1;
    repeat (hi) @(negedge clk);
    if (ch == 0)
      cmdA = 1'b0;
    else
      cmdB = 1'b0;
    @(negedge clk);
  endtask : pulse
endmodule : dcrly_source
`default_nettype wire

// file: verification/dcrly_top_bench.sv
// Purpose: self-checking bench of the relay pulse controller
// Assumes: small qualify and on-time counts to keep the run short
// Notes:   expected pulses are queued, a monitor measures real ones
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g); end end

module dcrly_top_bench;
  import dcrly_pkg::*;
  localparam int Q = 8;   // qualify count
  localparam int T = 40;  // on-time cap
  // expected result: channel 0 a, 1 b, 2 blocked; width in cycles
  typedef struct {int chan; int width;} dcrly_note_t;
  logic clk = 1'b0, rst = 1'b1, enable = 1'b1, thermalFault = 1'b0, fixedMode = 1'b0;
  logic cmdA, cmdB, coilDriveA, coilDriveB, busy, xorBlocked;
  logic [2:0] res;  // watched results
  int error_cnt = 0, n_compared = 0, cyc = 0, h, cnt[3];
  dcrly_note_t q[$];
  assign res = {xorBlocked, coilDriveB, coilDriveA};

  always #20 clk = ~clk;

  dcrly_top #(.QUAL_CYC(Q), .TMAX_CYC(T)) u_dcrly_top (.clk(clk), .rst(rst), .commandInA(cmdA),
    .commandInB(cmdB), .enable(enable), .thermalFault(thermalFault), .fixedMode(fixedMode),
    .coilDriveA(coilDriveA), .coilDriveB(coilDriveB), .busy(busy), .xorBlocked(xorBlocked));
  dcrly_source u_dcrly_source (.clk(clk), .cmdA(cmdA), .cmdB(cmdB));

  ////////////////////////////////////////////////////////////////////////////
  // note an expected result
  task automatic expect_res(input int ch, input int w);
    q.push_back('{ch, w});
  endtask : expect_res

  // let all activity finish, then nothing may remain unseen
  task automatic settle(input string nm);
    repeat (Q + T + 20) @(negedge clk);
    `CHK("missing results", 0, q.size())
    $display("test %s done", nm);
  endtask : settle

  // counts and verdict, end of run
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  // monitor: measure each pulse, compare with the oldest note
  always @(negedge clk) begin
    dcrly_note_t n;
    for (int k = 0; k < 3; k++) begin
      if (res[k] === 1'b1) begin
        cnt[k]++;
        if (k < 2)
          `CHK("busy", 1'b1, busy)
      end else if (cnt[k] > 0) begin
        if (q.size() == 0) begin
          `CHK("unexpected pulse", -1, k)
        end else begin
          n = q.pop_front();
          `CHK("pulse channel", n.chan, k)
          `CHK("pulse width", n.width, cnt[k])
        end
        cnt[k] = 0;
      end
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    h = $urandom(86906);
    cnt = '{0, 0, 0};
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    // follow mode copies the input width, delayed by the qualify time
    for (int c = 0; c < 2; c++) begin
      h = $urandom_range(Q + 20, Q + 3);
      expect_res(c, h);
      u_dcrly_source.pulse(c, h);
      settle("follow");
    end
    // too short a pulse is ignored
    u_dcrly_source.pulse(1, $urandom_range(Q - 1, 1));
    settle("short");
    // held high: one capped pulse only
    expect_res(0, T);
    u_dcrly_source.pulse(0, 3 * T);
    settle("stuck");
    // fixed mode: exactly the cap on a barely qualified input
    fixedMode = 1'b1;
    expect_res(1, T);
    u_dcrly_source.pulse(1, Q + 3);
    settle("fixed");
    // short noise on b while a qualifies: a waits only when the noise lasts Q - 2 cycles, then drives
    expect_res(0, T);
    fork
      u_dcrly_source.pulse(0, Q + 10);
      begin
        repeat (3) @(negedge clk);
        u_dcrly_source.pulse(1, $urandom_range(Q - 2, 1));
      end
    join
    settle("pending");
    // noise and a full command on b while a drives
    expect_res(0, T);
    fork
      u_dcrly_source.pulse(0, Q + 5);
      begin
        repeat (Q + 8) @(negedge clk);
        u_dcrly_source.pulse(1, 2);
        u_dcrly_source.pulse(1, 1);
        u_dcrly_source.pulse(1, Q + 6);
      end
    join
    settle("overlap");
    fixedMode = 1'b0;
    // both inputs rise together
    expect_res(2, 1);
    fork
      u_dcrly_source.pulse(0, Q + 5);
      u_dcrly_source.pulse(1, Q + 5);
    join
    settle("xor together");
    // second input qualifies while the first waits
    expect_res(2, 1);
    fork
      u_dcrly_source.pulse(0, Q + 10);
      begin
        repeat (3) @(negedge clk);
        u_dcrly_source.pulse(1, Q + 10);
      end
    join
    settle("xor late");
    // enable drop, then fault, cut a fixed pulse after ten cycles
    fixedMode = 1'b1;
    for (int k = 0; k < 2; k++) begin
      expect_res(0, 10);
      fork
        u_dcrly_source.pulse(0, Q + 5);
        begin
          for (int i = 0; i < Q + 20 && coilDriveA !== 1'b1; i++) @(negedge clk);
          repeat (9) @(negedge clk);
          if (k == 0)
            enable = 1'b0;
          else
            thermalFault = 1'b1;
          repeat (3) @(negedge clk);
          enable = 1'b1;
          thermalFault = 1'b0;
        end
      join
      settle("shutdown");
    end
    give_verdict();
  end
endmodule : dcrly_top_bench
`default_nettype wire
